//--- core/trp_pin_ctrl.v
// Timing receiver output pin control: master clock select, clock, sync and data pins
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "trp_pin_ctrl_map.vh"

module trp_pin_ctrl #(
  parameter NUM_XCVR = 2,
  parameter ADDR_W   = 8
) (
  input  wire                clk,
  input  wire                reset,
  // APB slave
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [ADDR_W-1:0]   paddr,
  input  wire [31:0]         pwdata,
  input  wire [3:0]          pstrb,
  output wire [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  // Pins and receiver-side signals, one bit per transceiver
  input  wire [NUM_XCVR-1:0] ext_xcvr_master_clock_in,
  input  wire [NUM_XCVR-1:0] rx_recovered_clk,
  input  wire [NUM_XCVR-1:0] rx_frame_sync,
  input  wire [NUM_XCVR-1:0] rx_mframe_sync,
  input  wire [NUM_XCVR-1:0] rx_nrz_data,
  output wire [NUM_XCVR-1:0] xcvr_master_clk,
  output wire [NUM_XCVR-1:0] recovered_clock_out,
  output wire [NUM_XCVR-1:0] rx_multipurpose_out,
  output wire [NUM_XCVR-1:0] rx_serial_data_out,
  output wire [NUM_XCVR-1:0] rx_serial_data_out_oe_n
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam [`TRP_ACC_W-1:0] ACC_INC  = `TRP_ACC_INC;
  localparam [`TRP_ACC_W-1:0] ACC_WRAP = `TRP_ACC_WRAP;
  localparam                  CW       = `TRP_CTRL_W;
  localparam                  MW       = `TRP_MODE_W;
  localparam                  SW       = `TRP_STAT_W;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [`TRP_ACC_W-1:0]  acc_ff;
  reg [`TRP_ACC_W-1:0]  nxt_acc;
  reg                   int_mclk_ff;
  reg                   nxt_int_mclk;

  reg [NUM_XCVR*CW-1:0] ctrl_ff;
  reg [NUM_XCVR*CW-1:0] nxt_ctrl;
  reg [NUM_XCVR*MW-1:0] mode_ff;
  reg [NUM_XCVR*MW-1:0] nxt_mode;

  reg [31:0]            prdata_ff;
  reg [31:0]            nxt_prdata;
  reg                   pready_ff;
  reg                   nxt_pready;
  reg                   pslverr_ff;
  reg                   nxt_pslverr;

  reg [NUM_XCVR-1:0]    mclk_ff;
  reg [NUM_XCVR-1:0]    nxt_mclk;
  reg [NUM_XCVR-1:0]    rclk_prev_ff;
  reg [NUM_XCVR-1:0]    rc_out_ff;
  reg [NUM_XCVR-1:0]    nxt_rc_out;
  reg [NUM_XCVR-1:0]    mp_out_ff;
  reg [NUM_XCVR-1:0]    nxt_mp_out;
  reg [NUM_XCVR-1:0]    ser_ff;
  reg [NUM_XCVR-1:0]    nxt_ser;
  reg [NUM_XCVR-1:0]    ser_oe_n_ff;
  reg [NUM_XCVR-1:0]    nxt_ser_oe_n;

  // Decode results
  reg                   hit_ctrl;
  reg                   hit_mode;
  reg                   hit_stat;
  reg [NUM_XCVR-1:0]    sel_xcvr;
  reg [31:0]            rd_word;
  reg [31:0]            stat_word;
  // One loop index per process, so no variable has two drivers
  integer               i_dec;
  integer               i_rd;
  integer               i_wr;
  integer               i_pin;
  integer               ofs;

  // --------------------------------------------------------------------------
  // Internal transceiver master clock
  // --------------------------------------------------------------------------
  // Fractional divider: the 204.8MHz/100 clock cannot be built at 50MHz
  // exactly, so edges land on the next system edge (20 ns of jitter).
  // The accumulator adds the output rate each cycle and toggles on every
  // wrap of half the system rate, so the long-term rate is exact.
  // Consumers that need a clean clock must retime it with a real PLL.
  always @* begin
    nxt_acc      = acc_ff + ACC_INC;
    nxt_int_mclk = int_mclk_ff;
    if (nxt_acc >= ACC_WRAP) begin
      nxt_acc      = nxt_acc - ACC_WRAP;
      nxt_int_mclk = ~int_mclk_ff;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      acc_ff      <= {`TRP_ACC_W{1'b0}};
      int_mclk_ff <= 1'b0;
    end else begin
      acc_ff      <= nxt_acc;
      int_mclk_ff <= nxt_int_mclk;
    end
  end

  // --------------------------------------------------------------------------
  // APB address decode
  // --------------------------------------------------------------------------
  // Only aligned word addresses hit; anything else answers with pslverr
  always @* begin
    hit_ctrl = 1'b0;
    hit_mode = 1'b0;
    hit_stat = 1'b0;
    sel_xcvr = {NUM_XCVR{1'b0}};
    ofs      = 0;
    // Control words first, one per transceiver
    for (i_dec = 0; i_dec < NUM_XCVR; i_dec = i_dec + 1) begin
      ofs = `TRP_CTRL_BASE + `TRP_REG_STRIDE * i_dec;
      if (paddr == ofs[ADDR_W-1:0]) begin
        hit_ctrl        = 1'b1;
        sel_xcvr[i_dec] = 1'b1;
      end
      // Mode words sit in their own bank above the control words
      ofs = `TRP_MODE_BASE + `TRP_REG_STRIDE * i_dec;
      if (paddr == ofs[ADDR_W-1:0]) begin
        hit_mode        = 1'b1;
        sel_xcvr[i_dec] = 1'b1;
      end
    end
    // Single status word shared by both transceivers
    ofs = `TRP_STAT_OFS;
    if (paddr == ofs[ADDR_W-1:0]) begin
      hit_stat = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Status word and read mux
  // --------------------------------------------------------------------------
  // Status shows the clock source control bit, the data pin drive enable and the sync and clock pin levels
  always @* begin
    stat_word = 32'h0000_0000;
    rd_word   = 32'h0000_0000;
    for (i_rd = 0; i_rd < NUM_XCVR; i_rd = i_rd + 1) begin
      // Status reflects registered pin values, not the next ones
      stat_word[i_rd*SW + `TRP_STAT_EXTCLK] = ctrl_ff[i_rd*CW + `TRP_CTRL_CLKSRC_BIT];
      stat_word[i_rd*SW + `TRP_STAT_SERACT] = ~ser_oe_n_ff[i_rd];
      stat_word[i_rd*SW + `TRP_STAT_MPOUT]  = mp_out_ff[i_rd];
      stat_word[i_rd*SW + `TRP_STAT_RCOUT]  = rc_out_ff[i_rd];
      // Unused upper bits read as zero
      if (sel_xcvr[i_rd] && hit_ctrl) begin
        rd_word[CW-1:0] = ctrl_ff[i_rd*CW +: CW];
      end
      if (sel_xcvr[i_rd] && hit_mode) begin
        rd_word[MW-1:0] = mode_ff[i_rd*MW +: MW];
      end
    end
    if (hit_stat) begin
      rd_word = stat_word;
    end
  end

  // --------------------------------------------------------------------------
  // APB handshake and register writes
  // --------------------------------------------------------------------------
  // Answer is prepared in the setup cycle so every bus output is a flop;
  // the cost is exactly one access cycle, never more.
  // Read data is zero outside the access cycle so stale words never leak.
  always @* begin
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata  = 32'h0000_0000;
    nxt_ctrl    = ctrl_ff;
    nxt_mode    = mode_ff;
    if (psel && !penable) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~(hit_ctrl | hit_mode | hit_stat);
      if (!pwrite) begin
        nxt_prdata = rd_word;
      end
    end
    // Write lands at the completing edge only; status is read-only
    // All fields live in the low byte, so only its strobe counts
    if (psel && penable && pready_ff && pwrite && pstrb[0]) begin
      for (i_wr = 0; i_wr < NUM_XCVR; i_wr = i_wr + 1) begin
        if (sel_xcvr[i_wr] && hit_ctrl) begin
          nxt_ctrl[i_wr*CW +: CW] = pwdata[CW-1:0];
        end
        if (sel_xcvr[i_wr] && hit_mode) begin
          nxt_mode[i_wr*MW +: MW] = pwdata[MW-1:0];
        end
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      ctrl_ff    <= {NUM_XCVR{`TRP_CTRL_RST}};
      mode_ff    <= {NUM_XCVR{`TRP_MODE_RST}};
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      ctrl_ff    <= nxt_ctrl;
      mode_ff    <= nxt_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Per-transceiver pin logic
  // --------------------------------------------------------------------------
  // All pin outputs move on the same system edge, one cycle after inputs.
  // Registering every pin costs one cycle of latency but keeps the pins
  // free of decode glitches while software rewrites a control word.
  always @* begin
    nxt_mclk     = mclk_ff;
    nxt_rc_out   = rc_out_ff;
    nxt_mp_out   = mp_out_ff;
    nxt_ser      = ser_ff;
    nxt_ser_oe_n = ser_oe_n_ff;
    for (i_pin = 0; i_pin < NUM_XCVR; i_pin = i_pin + 1) begin
      // Master clock source; external pin is not looked at when unselected.
      // The pin is sampled on the system clock, so an external clock must
      // stay well below half the system rate to pass through unaliased.
      if (ctrl_ff[i_pin*CW + `TRP_CTRL_CLKSRC_BIT]) begin
        nxt_mclk[i_pin] = ext_xcvr_master_clock_in[i_pin];
      end else begin
        nxt_mclk[i_pin] = int_mclk_ff;
      end

      // Recovered clock pin or static level; the invert bit only picks
      // the static level here, the running clock is never inverted
      if (ctrl_ff[i_pin*CW + `TRP_CTRL_RECCLK_EN_BIT]) begin
        nxt_rc_out[i_pin] = rx_recovered_clk[i_pin];
      end else begin
        nxt_rc_out[i_pin] = ctrl_ff[i_pin*CW + `TRP_CTRL_RECCLK_INV_BIT];
      end

      // Multipurpose pin: sync source, polarity from the invert bit
      if (ctrl_ff[i_pin*CW + `TRP_CTRL_MP_EN_BIT]) begin
        if (ctrl_ff[i_pin*CW + `TRP_CTRL_MP_SRC_BIT]) begin
          nxt_mp_out[i_pin] = rx_mframe_sync[i_pin] ^
                              ctrl_ff[i_pin*CW + `TRP_CTRL_MP_INV_BIT];
        end else begin
          nxt_mp_out[i_pin] = rx_frame_sync[i_pin] ^
                              ctrl_ff[i_pin*CW + `TRP_CTRL_MP_INV_BIT];
        end
      end else begin
        // Disabled pin doubles as a software-driven level
        nxt_mp_out[i_pin] = ctrl_ff[i_pin*CW + `TRP_CTRL_MP_INV_BIT];
      end

      // Serial data: forced low outside DS1/E1, tri-stated when disabled.
      // Mode is checked first so a non-framed mode never floats the pin.
      if (mode_ff[i_pin*MW + MW-1] != `TRP_MODE_DS1E1_MSB) begin
        nxt_ser[i_pin]      = 1'b0;
        nxt_ser_oe_n[i_pin] = 1'b0;
      end else if (!ctrl_ff[i_pin*CW + `TRP_CTRL_SER_EN_BIT]) begin
        nxt_ser[i_pin]      = 1'b0;
        nxt_ser_oe_n[i_pin] = 1'b1;
      end else begin
        nxt_ser_oe_n[i_pin] = 1'b0;
        // Rising edge of the receiver clock unless inverted, then falling;
        // data moves together with the clock pin, giving the consumer a
        // full half period of setup to the opposite edge
        if (ctrl_ff[i_pin*CW + `TRP_CTRL_RECCLK_INV_BIT] ?
            (rclk_prev_ff[i_pin] & ~rx_recovered_clk[i_pin]) :
            (~rclk_prev_ff[i_pin] & rx_recovered_clk[i_pin])) begin
          nxt_ser[i_pin] = rx_nrz_data[i_pin];
        end
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      mclk_ff      <= {NUM_XCVR{1'b0}};
      rclk_prev_ff <= {NUM_XCVR{1'b0}};
      rc_out_ff    <= {NUM_XCVR{1'b0}};
      mp_out_ff    <= {NUM_XCVR{1'b0}};
      ser_ff       <= {NUM_XCVR{1'b0}};
      ser_oe_n_ff  <= {NUM_XCVR{1'b1}};
    end else begin
      mclk_ff      <= nxt_mclk;
      rclk_prev_ff <= rx_recovered_clk;
      rc_out_ff    <= nxt_rc_out;
      mp_out_ff    <= nxt_mp_out;
      ser_ff       <= nxt_ser;
      ser_oe_n_ff  <= nxt_ser_oe_n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign prdata                  = prdata_ff;
  assign pready                  = pready_ff;
  assign pslverr                 = pslverr_ff;
  assign xcvr_master_clk         = mclk_ff;
  assign recovered_clock_out     = rc_out_ff;
  assign rx_multipurpose_out     = mp_out_ff;
  assign rx_serial_data_out      = ser_ff;
  assign rx_serial_data_out_oe_n = ser_oe_n_ff;

endmodule
`default_nettype wire

//--- core/trp_pin_ctrl_map.vh
// Register map, field positions, reset values and clock figures of the pin control block
`ifndef TRP_PIN_CTRL_MAP_VH
`define TRP_PIN_CTRL_MAP_VH

// ----------------------------------------------------------------------------
// Clock figures
// ----------------------------------------------------------------------------
// System clock of this logic, in kHz (20 ns period)
`define TRP_SYS_CLK_KHZ    50000
// Local oscillator reference, in kHz
`define TRP_LOCAL_OSC_KHZ  12800
// Multiplier from reference to device master clock
`define TRP_PLL_MULT       16
// Divider from device master clock to transceiver master clock
`define TRP_MCLK_DIV       100
// Device master clock in kHz (204800)
`define TRP_DEV_MCLK_KHZ   (`TRP_LOCAL_OSC_KHZ * `TRP_PLL_MULT)
// Transceiver master clock in kHz (2048)
`define TRP_XCVR_MCLK_KHZ  (`TRP_DEV_MCLK_KHZ / `TRP_MCLK_DIV)
// Phase accumulator step and wrap: two toggles per output period
`define TRP_ACC_INC        `TRP_XCVR_MCLK_KHZ
`define TRP_ACC_WRAP       (`TRP_SYS_CLK_KHZ / 2)
`define TRP_ACC_W          17

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define TRP_CTRL_BASE      8'h00
`define TRP_MODE_BASE      8'h20
`define TRP_STAT_OFS       8'h40
`define TRP_REG_STRIDE     4

// ----------------------------------------------------------------------------
// rx_clocking_ctrl_reg fields
// ----------------------------------------------------------------------------
`define TRP_CTRL_CLKSRC_BIT     0
`define TRP_CTRL_RECCLK_EN_BIT  1
`define TRP_CTRL_RECCLK_INV_BIT 2
`define TRP_CTRL_MP_EN_BIT      3
`define TRP_CTRL_MP_SRC_BIT     4
`define TRP_CTRL_MP_INV_BIT     5
`define TRP_CTRL_SER_EN_BIT     6
`define TRP_CTRL_W         7
`define TRP_CTRL_RST       7'h00

// ----------------------------------------------------------------------------
// xcvr_mode_ctrl_reg fields
// ----------------------------------------------------------------------------
`define TRP_MODE_W         2
`define TRP_MODE_RST       2'h0
// Upper mode bit clear means DS1 or E1
`define TRP_MODE_DS1E1_MSB 1'b0

// ----------------------------------------------------------------------------
// Status register fields (per transceiver, 4 bits each)
// ----------------------------------------------------------------------------
`define TRP_STAT_EXTCLK    0
`define TRP_STAT_SERACT    1
`define TRP_STAT_MPOUT     2
`define TRP_STAT_RCOUT     3
`define TRP_STAT_W         4

`endif

//--- verification/tb_trp_pin_ctrl.sv
// Testbench of the timing receiver pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_trp_pin_ctrl;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        inv = 1'b0;
  logic        chk_en = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [1:0]  ext, rec, frm, mfrm, nrz, mclk, rco, mpo, ser, oe_n;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_bad, n_seen, c, tg0, tg1;
  logic [1:0]  pm;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  addr [5] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h40};
  logic [31:0] lv [2] = '{32'h24, 32'h00};
  int          mp_exp [4] = '{32, 8, 224, 248};
  trp_pin_ctrl trp_pin_ctrl_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_xcvr_master_clock_in(ext),
    .rx_recovered_clk(rec), .rx_frame_sync(frm), .rx_mframe_sync(mfrm), .rx_nrz_data(nrz),
    .xcvr_master_clk(mclk), .recovered_clock_out(rco), .rx_multipurpose_out(mpo),
    .rx_serial_data_out(ser), .rx_serial_data_out_oe_n(oe_n));
  trp_far_model trp_far_model_i (.clk(clk), .reset(reset), .inv(inv), .chk_en(chk_en),
    .rc_out(rco), .ser_out(ser), .rec_clk(rec), .frm(frm), .mfrm(mfrm), .nrz(nrz),
    .ext_clk(ext), .n_bad(n_bad), .n_seen(n_seen));
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Counts high cycles of a pin: 0 sync, 1 clock, 2 data
  task automatic hi(input int sel, input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge clk);
      cnt += int'((sel == 0 ? mpo[0] : sel == 1 ? rco[0] : ser[0]) === 1'b1);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (addr[i]) begin
      apb(1'b0, addr[i], 32'h0);
      chk("reset word", rd, 32'h0);
    end
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, 8'h02, 32'h7f);
    chk("unaligned error", {31'h0, err}, 32'h1);
    apb(1'b1, 8'h40, 32'hff);
    pstrb <= 4'he;
    apb(1'b1, 8'h00, 32'h7f);
    pstrb <= 4'hf;
    apb(1'b1, 8'h04, 32'h01);
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h40, 32'h0);
    chk("status", rd, 32'h10);
    // Divider rate, exact over eight full accumulator cycles
    tg0 = 0;
    tg1 = 0;
    pm = mclk;
    repeat (25000) begin
      @(posedge clk);
      tg0 += int'(mclk[0] != pm[0]);
      tg1 += int'(mclk[1] != pm[1]);
      pm = mclk;
    end
    chk("internal clock toggles", tg0, 2048);
    chk("pin clock toggles", tg1, 25000);
    foreach (lv[i]) begin
      apb(1'b1, 8'h00, lv[i]);
      repeat (3) @(posedge clk);
      chk("clock pin level", rco[0], lv[i][2]);
      chk("sync pin level", mpo[0], lv[i][5]);
      chk("other clock pin", rco[1], 1'b0);
      chk("other sync pin", mpo[1], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 32'h0a | (i << 4));
      repeat (3) @(posedge clk);
      hi(0, 256, c);
      chk("sync pin high count", c, mp_exp[i]);
      hi(1, 256, c);
      chk("clock pin high count", c, 128);
    end
    // Every line mode, data enable off and on, both update edges
    for (int j = 0; j < 8; j++) begin
      inv <= j[0];
      apb(1'b1, 8'h20, j[1:0]);
      apb(1'b1, 8'h00, {j[2], 3'h0, j[0], 2'h2});
      repeat (12) @(posedge clk);
      chk("data enable", oe_n[0], j[1] ? 1'b0 : !j[2]);
      chk("other data enable", oe_n[1], 1'b1);
      chk("other data level", ser[1], 1'b0);
      chk_en <= !j[1] && j[2];
      hi(2, 64, c);
      chk_en <= 1'b0;
      if (j[1] || !j[2]) chk("idle data level", c, 0);
    end
    chk("data bits wrong", n_bad, 0);
    chk("data bits seen", n_seen > 8, 1);
    end_of_test();
  end
  // Watchdog, well beyond the expected run length
  initial begin
    #(20 * 40000);
    mismatches++;
    end_of_test();
  end
endmodule
bind trp_pin_ctrl trp_pin_ctrl_assertions #(.NUM_XCVR(NUM_XCVR), .ADDR_W(ADDR_W)) chk_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_xcvr_master_clock_in(ext_xcvr_master_clock_in),
  .rx_recovered_clk(rx_recovered_clk), .rx_frame_sync(rx_frame_sync),
  .rx_mframe_sync(rx_mframe_sync), .rx_nrz_data(rx_nrz_data),
  .xcvr_master_clk(xcvr_master_clk), .recovered_clock_out(recovered_clock_out),
  .rx_multipurpose_out(rx_multipurpose_out), .rx_serial_data_out(rx_serial_data_out),
  .rx_serial_data_out_oe_n(rx_serial_data_out_oe_n));
`default_nettype wire

//--- verification/trp_far_model.sv
// Far side: receiver-side stimulus and a consumer of the data pin
`timescale 1ns/1ps
`default_nettype none
module trp_far_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       inv,
  input  wire logic       chk_en,
  input  wire logic [1:0] rc_out,
  input  wire logic [1:0] ser_out,
  output logic [1:0]      rec_clk,
  output logic [1:0]      frm,
  output logic [1:0]      mfrm,
  output logic [1:0]      nrz,
  output logic [1:0]      ext_clk,
  output var int          n_bad,
  output var int          n_seen
);
  localparam logic [7:0] PAT = 8'h2d;
  logic [7:0] cnt_ff;
  logic       rco_ff;
  logic [5:0] ph;
  // Free-running phase, all rates scaled to the sampling clock
  always_ff @(posedge clk) begin
    cnt_ff <= reset ? 8'h00 : cnt_ff + 8'h01;
    rco_ff <= rc_out[0];
  end
  // Second receiver clock runs in opposite phase so cross-talk shows
  assign rec_clk = {~cnt_ff[2], cnt_ff[2]};
  assign frm     = {2{cnt_ff[5:3] == 3'h0}};
  assign mfrm    = {2{cnt_ff[7:3] == 5'h00}};
  assign ph      = cnt_ff[5:0] + (inv ? 6'h00 : 6'h04);
  assign nrz     = {2{PAT[ph[5:3]]}};
  // Kept running on purpose, so that an ignored pin is proven ignored
  assign ext_clk = {cnt_ff[0], cnt_ff[1]};
  // Sample on the edge opposite to the update edge
  always_ff @(posedge clk) begin
    if (reset) begin
      n_bad  <= 0;
      n_seen <= 0;
    end else if (chk_en && (rco_ff ^ rc_out[0]) && rc_out[0] == inv) begin
      n_seen <= n_seen + 1;
      if (ser_out[0] !== nrz[0]) n_bad <= n_bad + 1;
    end
  end
endmodule
`default_nettype wire

//--- verification/trp_pin_ctrl_assertions.sv
// Concurrent checks on the pin control block's top ports
`timescale 1ns/1ps
`default_nettype none
module trp_pin_ctrl_assertions #(
  parameter NUM_XCVR = 2,
  parameter ADDR_W   = 8
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_XCVR-1:0] ext_xcvr_master_clock_in,
  input wire logic [NUM_XCVR-1:0] rx_recovered_clk,
  input wire logic [NUM_XCVR-1:0] rx_frame_sync,
  input wire logic [NUM_XCVR-1:0] rx_mframe_sync,
  input wire logic [NUM_XCVR-1:0] rx_nrz_data,
  input wire logic [NUM_XCVR-1:0] xcvr_master_clk,
  input wire logic [NUM_XCVR-1:0] recovered_clock_out,
  input wire logic [NUM_XCVR-1:0] rx_multipurpose_out,
  input wire logic [NUM_XCVR-1:0] rx_serial_data_out,
  input wire logic [NUM_XCVR-1:0] rx_serial_data_out_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [6:0] c0_ff;
  logic [6:0] c1_ff;
  logic [1:0] m0_ff;
  logic [4:0] gap_ff;
  logic       mck_ff;
  wire        wr = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  // Copy of accepted writes only; refused ones leave it alone
  always_ff @(posedge clk) begin
    if (reset) begin
      c0_ff <= 7'h00;
      c1_ff <= 7'h00;
      m0_ff <= 2'h0;
    end else if (wr && paddr == 8'h00) c0_ff <= pwdata[6:0];
    else if (wr && paddr == 8'h04) c1_ff <= pwdata[6:0];
    else if (wr && paddr == 8'h20) m0_ff <= pwdata[1:0];
  end
  // Cycles since the master clock moved; a stalled divider shows here
  always_ff @(posedge clk) begin
    mck_ff <= xcvr_master_clk[0];
    if (reset || c0_ff[0] || mck_ff != xcvr_master_clk[0]) gap_ff <= 5'h00;
    else if (gap_ff != 5'h1f) gap_ff <= gap_ff + 5'h01;
  end
  // Update edge of the data pin, chosen by the clock invert bit
  sequence ser_edge_s;
    !m0_ff[1] && c0_ff[6] && rx_recovered_clk[0] != c0_ff[2]
      && $past(rx_recovered_clk[0]) == c0_ff[2];
  endsequence
  mclk_int_a: assert property (gap_ff <= 5'h0f)
    else $error("internal master clock stalled");
  mclk_ext_a: assert property (!$past(reset) && $past(c0_ff[0])
    |-> xcvr_master_clk[0] == $past(ext_xcvr_master_clock_in[0]))
    else $error("master clock not from its pin");
  rc_out_a: assert property (!$past(reset) |-> recovered_clock_out[0] ==
    ($past(c0_ff[1]) ? $past(rx_recovered_clk[0]) : $past(c0_ff[2])))
    else $error("clock pin wrong");
  rc_other_a: assert property (!$past(reset) |-> recovered_clock_out[1] ==
    ($past(c1_ff[1]) ? $past(rx_recovered_clk[1]) : $past(c1_ff[2])))
    else $error("second clock pin wrong");
  mp_out_a: assert property (!$past(reset) |-> rx_multipurpose_out[0] ==
    ($past(c0_ff[3]) ? ($past(c0_ff[4]) ? $past(rx_mframe_sync[0]) : $past(rx_frame_sync[0]))
    ^ $past(c0_ff[5]) : $past(c0_ff[5])))
    else $error("sync pin wrong");
  ser_oe_a: assert property (!$past(reset) |-> rx_serial_data_out_oe_n[0] ==
    ($past(m0_ff[1]) ? 1'b0 : !$past(c0_ff[6])))
    else $error("data pin enable wrong");
  ser_low_a: assert property (!$past(reset) && ($past(m0_ff[1]) || !$past(c0_ff[6]))
    |-> rx_serial_data_out[0] == 1'b0)
    else $error("idle data pin not low");
  ser_edge_a: assert property (ser_edge_s |=>
    rx_serial_data_out[0] == $past(rx_nrz_data[0]))
    else $error("data pin not updated");
  apb_rdy_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a one-cycle answer");
endmodule
`default_nettype wire
